// *** hvpp_consts.svh ***
`ifndef HVPP_CONSTS_SVH
`define HVPP_CONSTS_SVH

// Strobe action codes {hi,lo}
`define ACT_ADDR 2'h0
`define ACT_DATA 2'h1
`define ACT_CMD  2'h2
`define ACT_IDLE 2'h3

// Byte-select codes {high,low}
`define BSEL_LOW  2'h0
`define BSEL_HIGH 2'h1
`define BSEL_EXT  2'h2
`define BSEL_RSVD 2'h3

// Command bytes
`define CMD_NOP        8'h00
`define CMD_CHIP_ERASE 8'h80
`define CMD_WR_FUSE    8'h40
`define CMD_WR_LOCK    8'h20
`define CMD_WR_FLASH   8'h10
`define CMD_WR_EEPROM  8'h11
`define CMD_RD_SIG     8'h08
`define CMD_RD_FUSE    8'h04
`define CMD_RD_FLASH   8'h02
`define CMD_RD_EEPROM  8'h03

// Entry pattern: page latch, action hi, action lo, byte-select low
`define ENTRY_PATTERN 4'h0

// Timing
`define CLK_KHZ       10000
`define ENTRY_HOLD_NS 10000
`define ENTRY_HOLD_CYC ((`ENTRY_HOLD_NS * `CLK_KHZ + 999999) / 1000000)

// Reset values
`define CMD_RESET  8'h00
`define ADDR_RESET 8'h00

`endif

// *** hvpp_pkg.sv ***
package hvpp_pkg;

  // Port-level sequencer state
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ERASE_MEM,
    ST_ERASE_LOCK,
    ST_PROGRAM,
    ST_FUSE,
    ST_LOCK
  } seq_state_type;

  // Operation requested of the nonvolatile array
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ERASE_MEM,
    OP_CLEAR_LOCK,
    OP_PROG_FLASH,
    OP_PROG_EEPROM,
    OP_WRITE_FUSE,
    OP_WRITE_LOCK
  } nvm_op_type;

  // Read path selected by the loaded command
  typedef enum logic [2:0] {
    RD_NONE,
    RD_SIGNATURE,
    RD_FUSE_LOCK,
    RD_FLASH,
    RD_EEPROM
  } read_kind_type;

endpackage

// *** page_buf_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface page_buf_if #(
  parameter int IDX_W = 7
);
  logic             wrEn;
  logic [IDX_W-1:0] wrIdx;
  logic [15:0]      wrData;
  logic [IDX_W-1:0] rdIdx;
  logic [15:0]      rdData;

  modport writer (output wrEn, output wrIdx, output wrData, output rdIdx, input rdData);
  modport mem    (input wrEn, input wrIdx, input wrData, input rdIdx, output rdData);
endinterface

`default_nettype wire

// *** page_buffer.sv ***
`timescale 1ns/1ps
`default_nettype none

module page_buffer #(
  parameter int IDX_W = 7
) (
  // Clock
  input wire logic   ref_clk,
  // Access port
  page_buf_if.mem    bus
);
  logic [15:0] store [0:(1<<IDX_W)-1];
  logic [15:0] rdData_reg;

  // Write on latch, read data registered
  always_ff @(posedge ref_clk) begin
    if (bus.wrEn) begin
      store[bus.wrIdx] <= bus.wrData;
    end
    rdData_reg <= store[bus.rdIdx];
  end

  assign bus.rdData = rdData_reg;
endmodule

`default_nettype wire

// *** hv_prog_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hvpp_consts.svh"

// What this block does
// - Byte-select pair decodes address, data and fuse bytes; reads ignore it; others reserved.
// - Load strobe rise loads address, data or command by action code; 11 idles.
// - Decode write commands: erase, fuses, lock, flash, EEPROM.
// - Decode read commands: signature, fuse and lock, flash, EEPROM.
// - Programming mode ends on power loss or reset pin back to zero.
// - Command and address registers keep their values across operations.
// - Chip erase clears flash and lock, and EEPROM unless the keep fuse is programmed; never fuses.
// - Lock bits clear only after program memory erase completes.
// - EEPROM keep fuse programmed means erase spares EEPROM.
// - Write strobe fall after erase command starts erase, busy low.
// - Page latch rise copies data bytes into buffer at word address.
// - Low address bits pick word, upper bits plus low-byte top bits pick page.
// - Write strobe fall after address load programs whole page, busy low.
// - Ready flag is 0 while operating, 1 when ready for commands.
// - Command byte zero is no operation and clears write signals.
module hv_prog_port #(
  parameter int PAGE_IDX_W = 7
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // Programming-level reset detect
  input  wire logic                  hvActive,
  // Programmer strobes and selects
  input  wire logic                  load_strobe_pin,
  input  wire logic                  page_latch_strobe,
  input  wire logic                  writeStrobeN,
  input  wire logic                  outputEnableN,
  input  wire logic                  strobe_action_sel_hi,
  input  wire logic                  strobe_action_sel_lo,
  input  wire logic                  byte_select_low_bit,
  input  wire logic                  byte_select_high_bit,
  // Data pins
  input  wire logic [7:0]            dataIn,
  output logic      [7:0]            dataOut,
  output logic                       dataOe,
  // Fuse state
  input  wire logic                  eeprom_keep_fuse,
  // Nonvolatile array side
  input  wire logic                  nvmDone,
  input  wire logic [7:0]            nvmRdData,
  input  wire logic [PAGE_IDX_W-1:0] nvmBufIdx,
  output logic                       nvmStart,
  output hvpp_pkg::nvm_op_type       nvmOp,
  output logic                       nvmEraseEeprom,
  output logic      [1:0]            nvmByteSel,
  output logic      [23:0]           nvmAddr,
  output logic      [7:0]            nvmWrByte,
  output logic      [15:0]           nvmBufData,
  output hvpp_pkg::read_kind_type    readKind,
  // Status
  output logic                       progMode,
  output logic                       ready_busy_flag
);

  page_buf_if #(.IDX_W(PAGE_IDX_W)) pb ();

  page_buffer #(.IDX_W(PAGE_IDX_W)) u_buf (
    .ref_clk (ref_clk),
    .bus     (pb.mem)
  );

  localparam int HOLD_W = 8;

  // Registered state
  logic                    progMode_reg, progMode_next;
  logic [HOLD_W-1:0]       holdCnt_reg, holdCnt_next;
  logic                    hvSeen_reg, hvSeen_next;
  logic                    loadPrev_reg, pageLPrev_reg, wrPrev_reg;
  logic [7:0]              cmd_reg, cmd_next;
  logic [7:0]              addrLo_reg, addrLo_next;
  logic [7:0]              addrHi_reg, addrHi_next;
  logic [7:0]              addrExt_reg, addrExt_next;
  logic [7:0]              dataLo_reg, dataLo_next;
  logic [7:0]              dataHi_reg, dataHi_next;
  logic                    wrArmed_reg, wrArmed_next;
  logic [1:0]              fuseSel_reg, fuseSel_next;
  hvpp_pkg::seq_state_type state_reg, state_next;
  logic                    start_reg, start_next;
  hvpp_pkg::nvm_op_type    op_reg, op_next;
  logic                    eraseEe_reg, eraseEe_next;
  logic [7:0]              dOut_reg, dOut_next;
  logic                    dOe_reg, dOe_next;
  logic                    latchWr_reg, latchWr_next;
  logic                    ready_reg, ready_next;

  logic       loadRise, pageLRise, wrFall;
  logic [1:0] act, bsel;
  logic [3:0] entryPins;

  // Edge detection against last sampled level
  assign loadRise  = load_strobe_pin & ~loadPrev_reg;
  assign pageLRise = page_latch_strobe & ~pageLPrev_reg;
  assign wrFall    = ~writeStrobeN & wrPrev_reg;
  assign act       = {strobe_action_sel_hi, strobe_action_sel_lo};
  assign bsel      = {byte_select_high_bit, byte_select_low_bit};
  assign entryPins = {page_latch_strobe, strobe_action_sel_hi,
                      strobe_action_sel_lo, byte_select_low_bit};

  // Mode entry, loads, page latch and sequencer
  always_comb begin
    progMode_next = progMode_reg;
    holdCnt_next  = holdCnt_reg;
    hvSeen_next   = hvSeen_reg;
    cmd_next      = cmd_reg;
    addrLo_next   = addrLo_reg;
    addrHi_next   = addrHi_reg;
    addrExt_next  = addrExt_reg;
    dataLo_next   = dataLo_reg;
    dataHi_next   = dataHi_reg;
    wrArmed_next  = wrArmed_reg;
    fuseSel_next  = fuseSel_reg;
    state_next    = state_reg;
    start_next    = 1'b0;
    op_next       = op_reg;
    eraseEe_next  = eraseEe_reg;
    latchWr_next  = 1'b0;
    // Pattern must stay zero for the hold time after high voltage
    if (!hvActive) begin
      progMode_next = 1'b0;
      hvSeen_next   = 1'b0;
      holdCnt_next  = '0;
      cmd_next      = `CMD_RESET;
      wrArmed_next  = 1'b0;
      state_next    = hvpp_pkg::ST_IDLE;
    end else if (!progMode_reg) begin
      if (!hvSeen_reg) begin
        hvSeen_next  = 1'b1;
        holdCnt_next = '0;
      end else if (entryPins != `ENTRY_PATTERN) begin
        holdCnt_next = '0;
      end else if (holdCnt_reg >= HOLD_W'(`ENTRY_HOLD_CYC - 1)) begin
        progMode_next = 1'b1;
      end else begin
        holdCnt_next = holdCnt_reg + 1'b1;
      end
    end else begin
      // Loads on the load strobe, sampled at its edge
      if (loadRise && state_reg == hvpp_pkg::ST_IDLE) begin
        unique case (act)
          `ACT_ADDR: begin
            if (bsel == `BSEL_LOW) addrLo_next = dataIn;
            else if (bsel == `BSEL_HIGH) begin
              addrHi_next  = dataIn;
              wrArmed_next = (cmd_reg == `CMD_WR_FLASH) | (cmd_reg == `CMD_WR_EEPROM);
            end else if (bsel == `BSEL_EXT) addrExt_next = dataIn;
          end
          `ACT_DATA: begin
            if (bsel == `BSEL_HIGH) dataHi_next = dataIn;
            else if (bsel == `BSEL_LOW) dataLo_next = dataIn;
          end
          `ACT_CMD: begin
            cmd_next     = dataIn;
            wrArmed_next = (dataIn == `CMD_WR_FLASH) | (dataIn == `CMD_WR_EEPROM);
            if (dataIn == `CMD_NOP) wrArmed_next = 1'b0;
          end
          `ACT_IDLE: ;
        endcase
      end
      // Page latch copies both data bytes into the buffer
      if (pageLRise && state_reg == hvpp_pkg::ST_IDLE && wrArmed_reg) begin
        latchWr_next = 1'b1;
      end
      // Write strobe starts the operation chosen by the command
      unique case (state_reg)
        hvpp_pkg::ST_IDLE: begin
          if (wrFall) begin
            unique case (cmd_reg)
              `CMD_CHIP_ERASE: begin
                state_next   = hvpp_pkg::ST_ERASE_MEM;
                op_next      = hvpp_pkg::OP_ERASE_MEM;
                eraseEe_next = ~eeprom_keep_fuse;
                start_next   = 1'b1;
              end
              `CMD_WR_FLASH, `CMD_WR_EEPROM: begin
                if (wrArmed_reg) begin
                  state_next = hvpp_pkg::ST_PROGRAM;
                  op_next    = (cmd_reg == `CMD_WR_FLASH) ? hvpp_pkg::OP_PROG_FLASH
                                                          : hvpp_pkg::OP_PROG_EEPROM;
                  start_next = 1'b1;
                end
              end
              `CMD_WR_FUSE: begin
                if (bsel != `BSEL_RSVD) begin
                  state_next   = hvpp_pkg::ST_FUSE;
                  op_next      = hvpp_pkg::OP_WRITE_FUSE;
                  fuseSel_next = bsel;
                  start_next   = 1'b1;
                end
              end
              `CMD_WR_LOCK: begin
                state_next = hvpp_pkg::ST_LOCK;
                op_next    = hvpp_pkg::OP_WRITE_LOCK;
                start_next = 1'b1;
              end
              default: ;
            endcase
          end
        end
        hvpp_pkg::ST_ERASE_MEM: begin
          if (nvmDone) begin
            state_next = hvpp_pkg::ST_ERASE_LOCK;
            op_next    = hvpp_pkg::OP_CLEAR_LOCK;
            start_next = 1'b1;
          end
        end
        hvpp_pkg::ST_ERASE_LOCK, hvpp_pkg::ST_PROGRAM,
        hvpp_pkg::ST_FUSE, hvpp_pkg::ST_LOCK: begin
          if (nvmDone) begin
            state_next = hvpp_pkg::ST_IDLE;
            op_next    = hvpp_pkg::OP_NONE;
          end
        end
      endcase
    end
    // Ready flag is registered from the state about to be entered
    ready_next = (state_next == hvpp_pkg::ST_IDLE);
  end

  // Read data onto the pins while output enable is low
  always_comb begin
    dOe_next  = progMode_reg & ~outputEnableN & (readKind != hvpp_pkg::RD_NONE);
    dOut_next = dOe_next ? nvmRdData : 8'h00;
  end

  // Page buffer addressing
  assign pb.wrEn   = latchWr_reg;
  assign pb.wrIdx  = addrLo_reg[PAGE_IDX_W-1:0];
  assign pb.wrData = {dataHi_reg, dataLo_reg};
  assign pb.rdIdx  = nvmBufIdx;

  // State registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      progMode_reg  <= 1'b0;
      holdCnt_reg   <= '0;
      hvSeen_reg    <= 1'b0;
      loadPrev_reg  <= 1'b0;
      pageLPrev_reg <= 1'b0;
      wrPrev_reg    <= 1'b1;
      cmd_reg       <= `CMD_RESET;
      addrLo_reg    <= `ADDR_RESET;
      addrHi_reg    <= `ADDR_RESET;
      addrExt_reg   <= `ADDR_RESET;
      dataLo_reg    <= 8'h00;
      dataHi_reg    <= 8'h00;
      wrArmed_reg   <= 1'b0;
      fuseSel_reg   <= `BSEL_LOW;
      state_reg     <= hvpp_pkg::ST_IDLE;
      start_reg     <= 1'b0;
      op_reg        <= hvpp_pkg::OP_NONE;
      eraseEe_reg   <= 1'b0;
      dOut_reg      <= 8'h00;
      dOe_reg       <= 1'b0;
      latchWr_reg   <= 1'b0;
      ready_reg     <= 1'b1;
    end else begin
      progMode_reg  <= progMode_next;
      holdCnt_reg   <= holdCnt_next;
      hvSeen_reg    <= hvSeen_next;
      loadPrev_reg  <= load_strobe_pin;
      pageLPrev_reg <= page_latch_strobe;
      wrPrev_reg    <= writeStrobeN;
      cmd_reg       <= cmd_next;
      addrLo_reg    <= addrLo_next;
      addrHi_reg    <= addrHi_next;
      addrExt_reg   <= addrExt_next;
      dataLo_reg    <= dataLo_next;
      dataHi_reg    <= dataHi_next;
      wrArmed_reg   <= wrArmed_next;
      fuseSel_reg   <= fuseSel_next;
      state_reg     <= state_next;
      start_reg     <= start_next;
      op_reg        <= op_next;
      eraseEe_reg   <= eraseEe_next;
      dOut_reg      <= dOut_next;
      dOe_reg       <= dOe_next;
      latchWr_reg   <= latchWr_next;
      ready_reg     <= ready_next;
    end
  end

  // Read kind decoded from cmd_next, so it updates in the same cycle as cmd_reg
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      readKind <= hvpp_pkg::RD_NONE;
    end else begin
      unique case (cmd_next)
        `CMD_RD_SIG:    readKind <= hvpp_pkg::RD_SIGNATURE;
        `CMD_RD_FUSE:   readKind <= hvpp_pkg::RD_FUSE_LOCK;
        `CMD_RD_FLASH:  readKind <= hvpp_pkg::RD_FLASH;
        `CMD_RD_EEPROM: readKind <= hvpp_pkg::RD_EEPROM;
        default:        readKind <= hvpp_pkg::RD_NONE;
      endcase
    end
  end

  // Outputs straight from flops
  assign progMode        = progMode_reg;
  assign ready_busy_flag = ready_reg;
  assign nvmStart        = start_reg;
  assign nvmOp           = op_reg;
  assign nvmEraseEeprom  = eraseEe_reg;
  assign nvmByteSel      = fuseSel_reg;
  assign nvmAddr         = {addrExt_reg, addrHi_reg, addrLo_reg};
  assign nvmWrByte       = dataLo_reg;
  assign nvmBufData      = pb.rdData;
  assign dataOut         = dOut_reg;
  assign dataOe          = dOe_reg;

endmodule

`default_nettype wire

// *** hv_prog_port_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module hv_prog_port_monitor (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 rst,
  // Programmer side
  input wire logic                 hvActive,
  input wire logic                 writeStrobeN,
  input wire logic                 outputEnableN,
  input wire logic                 eeprom_keep_fuse,
  // Array side
  input wire logic                 nvmDone,
  input wire logic                 nvmStart,
  input wire hvpp_pkg::nvm_op_type nvmOp,
  input wire logic                 nvmEraseEeprom,
  // Status
  input wire logic                 dataOe,
  input wire logic                 progMode,
  input wire logic                 ready_busy_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Handshake with the array and the ready flag
  AST_START_BUSY: assert property (nvmStart |-> !ready_busy_flag)
    else $error("start while ready");
  AST_START_PULSE: assert property (nvmStart |=> !nvmStart)
    else $error("start longer than one cycle");
  AST_BUSY_HOLD: assert property (!ready_busy_flag && !nvmDone |=> !ready_busy_flag)
    else $error("ready without done");
  AST_READY_RETURN: assert property (nvmDone && !ready_busy_flag && nvmOp != hvpp_pkg::OP_ERASE_MEM
    |=> ready_busy_flag && nvmOp == hvpp_pkg::OP_NONE)
    else $error("ready not back after done");
  AST_ERASE_CHAIN: assert property (nvmDone && nvmOp == hvpp_pkg::OP_ERASE_MEM
    |=> nvmStart && nvmOp == hvpp_pkg::OP_CLEAR_LOCK && !ready_busy_flag)
    else $error("lock clear does not follow erase");
  AST_LOCK_AFTER_ERASE: assert property (nvmStart && nvmOp == hvpp_pkg::OP_CLEAR_LOCK
    |-> $past(nvmOp) == hvpp_pkg::OP_ERASE_MEM && $past(nvmDone))
    else $error("lock cleared early");
  AST_KEEP_EEPROM: assert property (nvmStart && nvmOp == hvpp_pkg::OP_ERASE_MEM
    |-> nvmEraseEeprom == !$past(eeprom_keep_fuse))
    else $error("eeprom erase flag wrong");
  AST_WR_EDGE: assert property (nvmStart && nvmOp != hvpp_pkg::OP_CLEAR_LOCK
    |-> $past(writeStrobeN, 2) && !$past(writeStrobeN))
    else $error("start without write strobe fall");
  // Mode entry, exit and read drive
  AST_EXIT: assert property (!hvActive |=> !progMode)
    else $error("mode kept without high voltage");
  AST_ENTRY: assert property ($rose(progMode) |-> $past(hvActive, 100))
    else $error("mode entered too early");
  AST_OE: assert property ($rose(dataOe) |-> !$past(outputEnableN) && progMode)
    else $error("data driven without enable");
endmodule

bind hv_prog_port hv_prog_port_monitor u_mon (.ref_clk, .rst, .hvActive, .writeStrobeN,
  .outputEnableN, .eeprom_keep_fuse, .nvmDone, .nvmStart, .nvmOp, .nvmEraseEeprom,
  .dataOe, .progMode, .ready_busy_flag);

`default_nettype wire

// *** nvm_array_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module nvm_array_model (
  // Clock and reset
  input wire logic         ref_clk,
  input wire logic         rst,
  // Requests from the port, latency from the bench
  input wire logic         nvmStart,
  input wire logic  [23:0] nvmAddr,
  input wire logic  [3:0]  lat,
  // Answers
  output logic             nvmDone,
  output logic      [7:0]  nvmRdData
);
  logic [3:0] cnt;

  // Busy time set per operation, never shorter than four cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cnt <= 4'h0;
    else if (nvmStart) cnt <= lat | 4'h4;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
  // Done pulse and an address-dependent read byte
  assign nvmDone = (cnt == 4'h1);
  assign nvmRdData = ~nvmAddr[7:0];
endmodule

`default_nettype wire

// *** test_parallel_hv_programming_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "hvpp_consts.svh"

module test_parallel_hv_programming_port;
  // Bench signals
  logic ref_clk, rst, hvActive, load_strobe_pin, page_latch_strobe, writeStrobeN;
  logic outputEnableN, strobe_action_sel_hi, strobe_action_sel_lo, dataOe, nvmDone;
  logic byte_select_low_bit, byte_select_high_bit, eeprom_keep_fuse, nvmStart;
  logic nvmEraseEeprom, progMode, ready_busy_flag;
  logic [7:0]  dataIn, dataOut, nvmRdData, nvmWrByte, lo, hi, ex;
  logic [6:0]  nvmBufIdx;
  logic [1:0]  nvmByteSel;
  logic [23:0] nvmAddr;
  logic [15:0] nvmBufData;
  logic [3:0]  lat;
  logic [31:0] seed, r;
  hvpp_pkg::nvm_op_type    nvmOp, opSeen;
  hvpp_pkg::read_kind_type readKind;
  logic [7:0]  cmds [5] = '{`CMD_RD_SIG, `CMD_RD_FUSE, `CMD_RD_FLASH, `CMD_RD_EEPROM,
                            `CMD_WR_FLASH};
  int n_fail = 0, cmp_count = 0, nStart = 0, i;

  hv_prog_port #(.PAGE_IDX_W(7)) u_dut (.ref_clk, .rst, .hvActive, .load_strobe_pin,
    .page_latch_strobe, .writeStrobeN, .outputEnableN, .strobe_action_sel_hi,
    .strobe_action_sel_lo, .byte_select_low_bit, .byte_select_high_bit, .dataIn, .dataOut,
    .dataOe, .eeprom_keep_fuse, .nvmDone, .nvmRdData, .nvmBufIdx, .nvmStart, .nvmOp,
    .nvmEraseEeprom, .nvmByteSel, .nvmAddr, .nvmWrByte, .nvmBufData, .readKind, .progMode,
    .ready_busy_flag);
  nvm_array_model u_nvm (.ref_clk, .rst, .nvmStart, .nvmAddr, .lat, .nvmDone, .nvmRdData);

  // Clock and start record
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (nvmStart === 1'b1) begin
    opSeen <= nvmOp;
    nStart <= nStart + 1;
  end

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Read path expected for a command byte
  function automatic hvpp_pkg::read_kind_type rk(input logic [7:0] c);
    case (c)
      `CMD_RD_SIG:    return hvpp_pkg::RD_SIGNATURE;
      `CMD_RD_FUSE:   return hvpp_pkg::RD_FUSE_LOCK;
      `CMD_RD_FLASH:  return hvpp_pkg::RD_FLASH;
      `CMD_RD_EEPROM: return hvpp_pkg::RD_EEPROM;
      default:        return hvpp_pkg::RD_NONE;
    endcase
  endfunction

  task automatic tick(input int n = 1);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One load strobe pulse; data changes after the edge
  task automatic ld(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
    {strobe_action_sel_hi, strobe_action_sel_lo} = a;
    {byte_select_high_bit, byte_select_low_bit} = b;
    dataIn = d;
    tick();
    load_strobe_pin = 1'b1;
    tick();
    load_strobe_pin = 1'b0;
    dataIn = ~d;
    tick();
  endtask
  task automatic wr();
    writeStrobeN = 1'b0;
    tick(2);
    writeStrobeN = 1'b1;
    tick();
  endtask
  task automatic wait_rdy();
    for (int k = 0; k < 100 && ready_busy_flag !== 1'b1; k++) tick();
    if (ready_busy_flag !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic erase(input logic f);
    eeprom_keep_fuse = f;
    ld(`ACT_CMD, `BSEL_LOW, `CMD_CHIP_ERASE);
    i = nStart;
    wr();
    lat = 4'(xs());
    chk("busy", ready_busy_flag, 0);
    chk("op", opSeen, hvpp_pkg::OP_ERASE_MEM);
    chk("eeErase", nvmEraseEeprom, !f);
    wait_rdy();
    chk("starts", nStart - i, 2);
    chk("op", opSeen, hvpp_pkg::OP_CLEAR_LOCK);
  endtask

  // Main sequence
  initial begin
    seed = 32'h0000_71f6;
    {rst, hvActive, load_strobe_pin, page_latch_strobe, outputEnableN} = 5'h11;
    {writeStrobeN, strobe_action_sel_hi, strobe_action_sel_lo, eeprom_keep_fuse} = 4'h8;
    {byte_select_high_bit, byte_select_low_bit, dataIn, nvmBufIdx, lat} = 0;
    repeat (5) @(posedge ref_clk);
    tick();
    rst = 1'b0;
    chk("prog", progMode, 0);
    chk("ready", ready_busy_flag, 1);
    chk("kind", readKind, hvpp_pkg::RD_NONE);
    // Wrong entry pattern, then the proper one held throughout
    page_latch_strobe = 1'b1;
    hvActive = 1'b1;
    tick(150);
    chk("prog", progMode, 0);
    {hvActive, page_latch_strobe} = 2'h0;
    tick(2);
    hvActive = 1'b1;
    tick(3000);
    chk("prog", progMode, 1);
    for (int c = 0; c < 5; c++) begin
      ld(`ACT_CMD, `BSEL_LOW, cmds[c]);
      chk("kind", readKind, rk(cmds[c]));
    end
    r = xs();
    {ex, hi, lo} = r[23:0];
    ld(`ACT_ADDR, `BSEL_LOW, lo);
    ld(`ACT_ADDR, `BSEL_HIGH, hi);
    ld(`ACT_ADDR, `BSEL_EXT, ex);
    ld(`ACT_ADDR, `BSEL_RSVD, ~lo);
    ld(`ACT_IDLE, `BSEL_LOW, ~hi);
    chk("addr", nvmAddr, {ex, hi, lo});
    ld(`ACT_CMD, `BSEL_LOW, `CMD_RD_FLASH);
    outputEnableN = 1'b0;
    tick(3);
    chk("oe", dataOe, 1);
    chk("rd", dataOut, 8'(~lo));
    outputEnableN = 1'b1;
    erase(1'b0);
    erase(1'b1);
    chk("addr", nvmAddr, {ex, hi, lo});
    ld(`ACT_CMD, `BSEL_LOW, `CMD_WR_FLASH);
    for (int w = 0; w < 2; w++) begin
      r = xs();
      ld(`ACT_ADDR, `BSEL_LOW, r[7:0]);
      ld(`ACT_DATA, `BSEL_LOW, r[15:8]);
      ld(`ACT_DATA, `BSEL_HIGH, r[23:16]);
      page_latch_strobe = 1'b1;
      tick();
      page_latch_strobe = 1'b0;
      nvmBufIdx = r[6:0];
      tick(4);
      chk("buf", nvmBufData, r[23:8]);
    end
    ld(`ACT_ADDR, `BSEL_HIGH, hi);
    i = nStart;
    wr();
    wait_rdy();
    chk("op", opSeen, hvpp_pkg::OP_PROG_FLASH);
    chk("starts", nStart - i, 1);
    chk("addr", nvmAddr, {ex, hi, r[7:0]});
    ld(`ACT_CMD, `BSEL_LOW, `CMD_NOP);
    i = nStart;
    wr();
    tick(5);
    chk("starts", nStart - i, 0);
    // Page latch after the no-operation command must not touch the buffer
    ld(`ACT_DATA, `BSEL_LOW, ~r[15:8]);
    page_latch_strobe = 1'b1;
    tick();
    page_latch_strobe = 1'b0;
    tick(4);
    chk("buf", nvmBufData, r[23:8]);
    r = xs();
    ld(`ACT_CMD, `BSEL_LOW, `CMD_WR_FUSE);
    ld(`ACT_DATA, `BSEL_LOW, r[7:0]);
    {byte_select_high_bit, byte_select_low_bit} = `BSEL_HIGH;
    wr();
    chk("op", opSeen, hvpp_pkg::OP_WRITE_FUSE);
    chk("fuseSel", nvmByteSel, `BSEL_HIGH);
    chk("fuseVal", nvmWrByte, r[7:0]);
    wait_rdy();
    ld(`ACT_CMD, `BSEL_LOW, `CMD_WR_LOCK);
    wr();
    chk("op", opSeen, hvpp_pkg::OP_WRITE_LOCK);
    wait_rdy();
    // EEPROM page program, then a fuse write with the reserved select
    ld(`ACT_CMD, `BSEL_LOW, `CMD_WR_EEPROM);
    ld(`ACT_ADDR, `BSEL_HIGH, hi);
    wr();
    chk("op", opSeen, hvpp_pkg::OP_PROG_EEPROM);
    wait_rdy();
    ld(`ACT_CMD, `BSEL_LOW, `CMD_WR_FUSE);
    {byte_select_high_bit, byte_select_low_bit} = `BSEL_RSVD;
    i = nStart;
    wr();
    tick(5);
    chk("starts", nStart - i, 0);
    hvActive = 1'b0;
    tick(2);
    chk("prog", progMode, 0);
    report_and_stop();
  end
endmodule

`default_nettype wire
